// ### design/cgc_regs.vh
/*
 * Clock generator control constants: offsets, fields, resets, codes.
 * Assumes inclusion by bare name from design/.
 */
`ifndef CGC_REGS_VH
`define CGC_REGS_VH

// ****************
// Register byte offsets (32-bit aligned words)
// ****************
`define CGC_OFS_STATUS_CTL   8'h00
`define CGC_OFS_SYS_CLK_CTL  8'h04
`define CGC_OFS_PLL_CTL      8'h08
`define CGC_OFS_FREQ_SEL     8'h0C
`define CGC_OFS_SUPPLY_MODE  8'h10
`define CGC_OFS_MODE_STAT    8'h14

// ****************
// Field positions
// ****************
`define CGC_BIT_MAIN_STOP    7
`define CGC_BIT_SUB_STOP     6
`define CGC_BIT_FAST_STOP    0
`define CGC_BIT_SRC_SEL      4
`define CGC_BIT_SRC_STAT     5
`define CGC_BIT_PLL_ON       0
`define CGC_BIT_PLL_SEL      1
`define CGC_BIT_PLL_DIV4     2
`define CGC_BIT_ITMR_CLK     4
`define CGC_BIT_ST_STOP      0
`define CGC_BIT_ST_HALT      1
`define CGC_BIT_ST_SLOW      2
`define CGC_BIT_ST_BUSY      3
`define CGC_BIT_ST_REFUSED   4

// ****************
// Reset values
// ****************
`define CGC_RST_STATUS_CTL   8'hC0
`define CGC_RST_SYS_CLK_CTL  8'h00
`define CGC_RST_PLL_CTL      8'h00
`define CGC_RST_SUPPLY_MODE  8'h00

// ****************
// Fast oscillator frequency codes: 32,24,16,12,8,6,4,3,2,1 MHz
// ****************
`define CGC_FREQ_LAST        4'h9
`define CGC_FREQ_4MHZ        4'h6
`define CGC_PLL_MULT         16

// ****************
// Bus answers
// ****************
`define CGC_RESP_OKAY        2'h0
`define CGC_RESP_SLVERR      2'h2

`endif

// ### design/cgc_top.v
/*
 * Clock generator control: oscillator enables, glitch-free source
 * switch, PLL, standby, behind an AXI4-Lite slave.
 * Assumes one clock; outside muxes obey the outputs; ticks async.
 */
// Design decisions made here: the AXI4-Lite register port and the address map.
// Contract
// - Stop crystal and external main on STOP/bit
// - Fast oscillator frequency from option, software-changeable
// - After reset CPU runs from fast oscillator
// - Stop fast oscillator on STOP or bit
// - Main source select bit picks source
// - PLL only at 4 MHz, x16, div 2/4 (4 MHz enforced only while on fast oscillator)
// - PLL on bit stops PLL
// - Refuse STOP while PLL output selected
// - Subsystem stop bit stops sub clock
// - Low-speed oscillator never clocks the CPU
// - Low-speed runs if watchdog or timer select
// - Low-speed stops in standby under three conditions
`include "cgc_regs.vh"
`default_nettype none

module cgc_top (
    input  wire        sys_clk_i,        // System clock, 25 MHz
    input  wire        rst_i,            // Async reset, active high
    input  wire        ce_i,             // Clock enable, freezes all state
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr_i,
    input  wire        s_axi_awvalid_i,
    output wire        s_axi_awready_o,
    input  wire [31:0] s_axi_wdata_i,
    input  wire [3:0]  s_axi_wstrb_i,
    input  wire        s_axi_wvalid_i,
    output wire        s_axi_wready_o,
    output wire [1:0]  s_axi_bresp_o,
    output wire        s_axi_bvalid_o,
    input  wire        s_axi_bready_i,
    input  wire [7:0]  s_axi_araddr_i,
    input  wire        s_axi_arvalid_i,
    output wire        s_axi_arready_o,
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0]  s_axi_rresp_o,
    output wire        s_axi_rvalid_o,
    input  wire        s_axi_rready_i,
    // CPU standby requests, same clock
    input  wire        stop_req_i,       // STOP instruction pulse
    input  wire        halt_req_i,       // HALT instruction pulse
    input  wire        wake_i,           // Wakeup pulse, ends standby
    // Option byte, stable from reset
    input  wire        opt_wdt_enable_i, // Watchdog enable option
    input  wire        opt_wdt_standby_i,// Watchdog standby-run option
    input  wire [3:0]  opt_fast_freq_i,  // Initial fast frequency code
    // Source activity ticks, asynchronous
    input  wire        hs_clk_tick_i,    // High-speed system clock tick
    input  wire        fast_clk_tick_i,  // Fast oscillator clock tick
    // Clock steering outputs
    output wire        main_osc_en_o,
    output wire        ext_main_clk_en_o,
    output wire        fast_osc_en_o,
    output wire [3:0]  fast_osc_freq_o,
    output wire        main_src_hs_o,    // 1 high-speed system, 0 fast osc
    output wire        sub_osc_en_o,
    output wire        ext_sub_clk_en_o,
    output wire        pll_en_o,
    output wire        pll_out_sel_o,
    output wire        pll_div4_o,
    output wire        slow_osc_en_o,
    output wire        stop_mode_o,
    output wire        halt_mode_o,
    output wire        stop_refused_o    // One-cycle pulse
);

    // ****************************************************************
    // Switch state machine codes
    // ****************************************************************
    localparam [2:0] SW_IDLE = 3'b001;   // Sources agree
    localparam [2:0] SW_OLD  = 3'b010;   // Waiting for old edge
    localparam [2:0] SW_NEW  = 3'b100;   // Waiting for new edge

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [7:0]  status_ctl_ff;           // clock_operation_status_reg
    reg  [7:0]  sys_clk_ctl_ff;          // system_clock_control_reg
    reg  [7:0]  pll_ctl_ff;              // pll_control_reg
    reg  [3:0]  freq_sel_ff;             // fast_internal_osc_freq_select
    reg  [7:0]  supply_mode_ff;          // subsystem_supply_mode_reg
    reg         opt_loaded_ff;           // Option byte captured
    reg         wdt_en_ff;               // Captured watchdog enable
    reg         wdt_stby_ff;             // Captured standby-run option
    reg         stop_ff;                 // In STOP mode
    reg         halt_ff;                 // In HALT mode
    reg         refused_ff;              // Refusal pulse
    reg         refused_seen_ff;         // Sticky refusal flag
    reg  [2:0]  sw_state_ff;             // Switch state
    reg         active_hs_ff;            // Source actually in use
    reg  [2:0]  hs_sync_ff;              // Sync pair plus edge history
    reg  [2:0]  fast_sync_ff;            // Sync pair plus edge history
    reg         main_osc_en_ff;
    reg         fast_osc_en_ff;
    reg         sub_osc_en_ff;
    reg         pll_en_ff;
    reg         slow_osc_en_ff;
    // Bus state
    reg         aw_held_ff;              // Write address captured
    reg         w_held_ff;               // Write data captured
    reg  [7:0]  aw_addr_ff;
    reg  [31:0] w_data_ff;
    reg         w_strb0_ff;              // Low byte lane enable
    reg         bvalid_ff;
    reg  [1:0]  bresp_ff;
    reg         rvalid_ff;
    reg  [31:0] rdata_ff;
    reg  [1:0]  rresp_ff;

    // ****************************************************************
    // Address decode, used by both read and write paths
    // ****************************************************************
    function addr_ok;
        input [7:0] a;
        begin
            addr_ok = (a[1:0] == 2'h0) && (a <= `CGC_OFS_MODE_STAT);
        end
    endfunction

    // ****************************************************************
    // Combinational helpers
    // ****************************************************************
    wire hs_edge   = hs_sync_ff[1] & ~hs_sync_ff[2];     // Rising tick, second stage
    wire fast_edge = fast_sync_ff[1] & ~fast_sync_ff[2];
    wire want_hs   = sys_clk_ctl_ff[`CGC_BIT_SRC_SEL];
    wire pll_sel   = pll_ctl_ff[`CGC_BIT_PLL_SEL];
    wire itmr_slow = supply_mode_ff[`CGC_BIT_ITMR_CLK];
    wire do_write  = aw_held_ff & w_held_ff & ~bvalid_ff;
    wire wr_lane   = do_write & w_strb0_ff;
    wire [7:0] wbyte = w_data_ff[7:0];
    // PLL input must be 4 MHz; only checkable on the fast oscillator
    wire pll_input_ok = active_hs_ff | (freq_sel_ff == `CGC_FREQ_4MHZ);
    wire [7:0] mode_stat = {3'h0, refused_seen_ff, (sw_state_ff != SW_IDLE),
                            slow_osc_en_ff, halt_ff, stop_ff};

    // ****************************************************************
    // Next-value logic for oscillator enables
    // ****************************************************************
    reg nxt_main_osc_en;
    reg nxt_fast_osc_en;
    reg nxt_sub_osc_en;
    reg nxt_pll_en;
    reg nxt_slow_osc_en;
    always @* begin
        nxt_main_osc_en = ~status_ctl_ff[`CGC_BIT_MAIN_STOP] & ~stop_ff;
        nxt_fast_osc_en = ~status_ctl_ff[`CGC_BIT_FAST_STOP] & ~stop_ff;
        nxt_sub_osc_en  = ~status_ctl_ff[`CGC_BIT_SUB_STOP];
        nxt_pll_en      = pll_ctl_ff[`CGC_BIT_PLL_ON] & pll_input_ok;
        // Runs on watchdog or interval timer demand
        nxt_slow_osc_en = wdt_en_ff | itmr_slow;
        // Standby gating only when the timer does not need it
        if ((stop_ff | halt_ff) & wdt_en_ff & ~itmr_slow & ~wdt_stby_ff) begin
            nxt_slow_osc_en = 1'b0;
        end
    end

    // ****************************************************************
    // Synchronisers for the source ticks
    // ****************************************************************
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hs_sync_ff   <= 3'h0;
            fast_sync_ff <= 3'h0;
        end else if (ce_i) begin
            // Bit 0 feeds bit 1 only; bit 2 is edge history
            hs_sync_ff   <= {hs_sync_ff[1:0], hs_clk_tick_i};
            fast_sync_ff <= {fast_sync_ff[1:0], fast_clk_tick_i};
        end
    end

    // ****************************************************************
    // Glitch-free source handover
    // ****************************************************************
    // A switch waits for an edge of the old source, then of the new one;
    // a stopped target leaves the switch pending rather than glitching.
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sw_state_ff  <= SW_IDLE;
            active_hs_ff <= 1'b0;        // Fast oscillator after reset
        end else if (ce_i) begin
            case (sw_state_ff)
                SW_IDLE: begin
                    if (want_hs != active_hs_ff) begin
                        sw_state_ff <= SW_OLD;
                    end
                end
                SW_OLD: begin
                    if (active_hs_ff ? hs_edge : fast_edge) begin
                        sw_state_ff <= SW_NEW;
                    end
                end
                SW_NEW: begin
                    if (active_hs_ff ? fast_edge : hs_edge) begin
                        active_hs_ff <= ~active_hs_ff;
                        sw_state_ff  <= SW_IDLE;
                    end
                end
                default: begin
                    sw_state_ff <= SW_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Standby entry and exit
    // ****************************************************************
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stop_ff         <= 1'b0;
            halt_ff         <= 1'b0;
            refused_ff      <= 1'b0;
            refused_seen_ff <= 1'b0;
        end else if (ce_i) begin
            refused_ff <= 1'b0;
            if (wake_i) begin
                stop_ff <= 1'b0;
                halt_ff <= 1'b0;
            end else if (stop_req_i & pll_sel) begin
                // Software must drop the PLL first
                refused_ff <= 1'b1;
            end else if (stop_req_i) begin
                stop_ff <= 1'b1;
            end else if (halt_req_i) begin
                halt_ff <= 1'b1;
            end
            // Set beats clear on the same edge
            if (stop_req_i & pll_sel & ~wake_i) begin
                refused_seen_ff <= 1'b1;
            end else if (wr_lane && aw_addr_ff == `CGC_OFS_MODE_STAT &&
                         wbyte[`CGC_BIT_ST_REFUSED]) begin
                refused_seen_ff <= 1'b0;  // Write one to clear
            end
        end
    end

    // ****************************************************************
    // Control registers and option byte capture
    // ****************************************************************
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_ctl_ff  <= `CGC_RST_STATUS_CTL;
            sys_clk_ctl_ff <= `CGC_RST_SYS_CLK_CTL;
            pll_ctl_ff     <= `CGC_RST_PLL_CTL;
            supply_mode_ff <= `CGC_RST_SUPPLY_MODE;
            freq_sel_ff    <= 4'h0;
            opt_loaded_ff  <= 1'b0;
            wdt_en_ff      <= 1'b0;
            wdt_stby_ff    <= 1'b0;
        end else if (ce_i) begin
            if (!opt_loaded_ff) begin
                // Option byte caught once after release
                opt_loaded_ff <= 1'b1;
                wdt_en_ff     <= opt_wdt_enable_i;
                wdt_stby_ff   <= opt_wdt_standby_i;
                if (opt_fast_freq_i <= `CGC_FREQ_LAST) begin
                    freq_sel_ff <= opt_fast_freq_i;
                end
            end else if (wr_lane) begin
                case (aw_addr_ff)
                    `CGC_OFS_STATUS_CTL: begin
                        status_ctl_ff <= wbyte & 8'hC1;
                    end
                    `CGC_OFS_SYS_CLK_CTL: begin
                        sys_clk_ctl_ff <= wbyte & 8'h10;
                    end
                    `CGC_OFS_PLL_CTL: begin
                        pll_ctl_ff <= wbyte & 8'h07;
                    end
                    `CGC_OFS_FREQ_SEL: begin
                        // Unlisted codes are ignored
                        if (wbyte[3:0] <= `CGC_FREQ_LAST && wbyte[7:4] == 4'h0) begin
                            freq_sel_ff <= wbyte[3:0];
                        end
                    end
                    `CGC_OFS_SUPPLY_MODE: begin
                        supply_mode_ff <= wbyte & 8'h10;
                    end
                    default: begin
                        status_ctl_ff <= status_ctl_ff;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Output flops for oscillator steering
    // ****************************************************************
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            main_osc_en_ff <= 1'b0;
            fast_osc_en_ff <= 1'b1;      // CPU needs it from the start
            sub_osc_en_ff  <= 1'b0;
            pll_en_ff      <= 1'b0;
            slow_osc_en_ff <= 1'b0;
        end else if (ce_i) begin
            main_osc_en_ff <= nxt_main_osc_en;
            fast_osc_en_ff <= nxt_fast_osc_en;
            sub_osc_en_ff  <= nxt_sub_osc_en;
            pll_en_ff      <= nxt_pll_en;
            slow_osc_en_ff <= nxt_slow_osc_en;
        end
    end

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff  <= 32'h0000_0000;
            w_strb0_ff <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `CGC_RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_awvalid_i & ~aw_held_ff) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i & ~w_held_ff) begin
                w_held_ff  <= 1'b1;
                w_data_ff  <= s_axi_wdata_i;
                w_strb0_ff <= s_axi_wstrb_i[0];
            end
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= addr_ok(aw_addr_ff) ? `CGC_RESP_OKAY : `CGC_RESP_SLVERR;
            end else if (bvalid_ff & s_axi_bready_i) begin
                bvalid_ff  <= 1'b0;
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `CGC_RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_arvalid_i & ~rvalid_ff) begin
                rvalid_ff <= 1'b1;
                rresp_ff  <= addr_ok(s_axi_araddr_i) ? `CGC_RESP_OKAY : `CGC_RESP_SLVERR;
                case (s_axi_araddr_i)
                    `CGC_OFS_STATUS_CTL:  rdata_ff <= {24'h0, status_ctl_ff};
                    `CGC_OFS_SYS_CLK_CTL: rdata_ff <= {26'h0, active_hs_ff,
                                                       sys_clk_ctl_ff[4:0]};
                    `CGC_OFS_PLL_CTL:     rdata_ff <= {24'h0, pll_ctl_ff};
                    `CGC_OFS_FREQ_SEL:    rdata_ff <= {28'h0, freq_sel_ff};
                    `CGC_OFS_SUPPLY_MODE: rdata_ff <= {24'h0, supply_mode_ff};
                    `CGC_OFS_MODE_STAT:   rdata_ff <= {24'h0, mode_stat};
                    default:              rdata_ff <= 32'h0000_0000;
                endcase
            end else if (rvalid_ff & s_axi_rready_i) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Outputs, all straight from flops
    // ****************************************************************
    // Ready high only while a channel's holding slot is free
    assign s_axi_awready_o   = ~aw_held_ff;
    assign s_axi_wready_o    = ~w_held_ff;
    assign s_axi_bresp_o     = bresp_ff;
    assign s_axi_bvalid_o    = bvalid_ff;
    assign s_axi_arready_o   = ~rvalid_ff;
    assign s_axi_rdata_o     = rdata_ff;
    assign s_axi_rresp_o     = rresp_ff;
    assign s_axi_rvalid_o    = rvalid_ff;
    assign main_osc_en_o     = main_osc_en_ff;
    assign ext_main_clk_en_o = main_osc_en_ff;
    assign fast_osc_en_o     = fast_osc_en_ff;
    assign fast_osc_freq_o   = freq_sel_ff;
    // Main source only ever high-speed or fast oscillator, never slow
    assign main_src_hs_o     = active_hs_ff;
    assign sub_osc_en_o      = sub_osc_en_ff;
    assign ext_sub_clk_en_o  = sub_osc_en_ff;
    assign pll_en_o          = pll_en_ff;
    assign pll_out_sel_o     = pll_ctl_ff[`CGC_BIT_PLL_SEL];
    assign pll_div4_o        = pll_ctl_ff[`CGC_BIT_PLL_DIV4];
    assign slow_osc_en_o     = slow_osc_en_ff;
    assign stop_mode_o       = stop_ff;
    assign halt_mode_o       = halt_ff;
    assign stop_refused_o    = refused_ff;

endmodule

`default_nettype wire

// ### dv/cgc_assertions.sv
/* Port checker for cgc_top: standby, refusal and enables.
   Assumes binding into cgc_top, one clock domain. */
`default_nettype none
module cgc_assertions (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic stop_req_i,
    input wire logic wake_i,
    input wire logic opt_wdt_enable_i,
    input wire logic main_osc_en_o,
    input wire logic ext_main_clk_en_o,
    input wire logic fast_osc_en_o,
    input wire logic main_src_hs_o,
    input wire logic pll_out_sel_o,
    input wire logic slow_osc_en_o,
    input wire logic stop_mode_o,
    input wire logic halt_mode_o,
    input wire logic stop_refused_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    chk_stop_refused: assert property (ce_i && stop_req_i && pll_out_sel_o && !wake_i
        |=> stop_refused_o) else $error("stop not refused");
    chk_refusal_cause: assert property (stop_refused_o
        |-> $past(stop_req_i) && $past(pll_out_sel_o)) else $error("refusal without cause");
    chk_stop_entry: assert property (ce_i && stop_req_i && !pll_out_sel_o && !wake_i
        |=> stop_mode_o) else $error("stop not entered");
    chk_main_off: assert property (ce_i && stop_mode_o
        |=> !main_osc_en_o && !ext_main_clk_en_o) else $error("main osc on in stop");
    chk_fast_off: assert property (ce_i && stop_mode_o |=> !fast_osc_en_o)
        else $error("fast osc on in stop");
    chk_reset_src: assert property ($fell(rst_i) |-> !main_src_hs_o && fast_osc_en_o)
        else $error("cpu not on fast osc");
    chk_slow_runs: assert property (ce_i && !stop_mode_o && !halt_mode_o && opt_wdt_enable_i
        && !$past(rst_i, 2) |=> slow_osc_en_o)
        else $error("slow osc stopped");
    chk_slow_drop: assert property ($fell(slow_osc_en_o) && opt_wdt_enable_i
        |-> $past(stop_mode_o || halt_mode_o))
        else $error("slow osc dropped");
endmodule
bind cgc_top cgc_assertions chk (.*);
`default_nettype wire

// ### dv/cgc_src_model.sv
/* Clock source activity model: ticks follow the oscillator enables.
   Assumes enables from cgc_top; the bench may stall the hs source. */
`default_nettype none
module cgc_src_model (
    input  wire logic hs_en_i,
    input  wire logic hs_run_i,
    input  wire logic fast_en_i,
    output var  logic hs_tick_o,
    output var  logic fast_tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle low until a source starts
    initial {hs_tick_o, fast_tick_o} = 2'h0;
    // Periods unrelated to the bus clock; a stopped source stands still
    always #67 if (hs_en_i && hs_run_i) hs_tick_o = ~hs_tick_o;
    always #53 if (fast_en_i) fast_tick_o = ~fast_tick_o;
endmodule
`default_nettype wire

// ### dv/tb.sv
/* Self-checking bench for cgc_top over its AXI4-Lite port.
   Assumes the design, source model and checker are compiled first. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i, rst_i, ce_i, stop_req_i, halt_req_i, wake_i, hs_run, hs_clk_tick_i;
    logic opt_wdt_enable_i, opt_wdt_standby_i, fast_clk_tick_i, s_axi_awvalid_i, s_axi_wvalid_i;
    logic s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
    logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, main_osc_en_o, ext_main_clk_en_o;
    logic fast_osc_en_o, main_src_hs_o, sub_osc_en_o, ext_sub_clk_en_o, pll_en_o, pll_out_sel_o;
    logic pll_div4_o, slow_osc_en_o, stop_mode_o, halt_mode_o, stop_refused_o;
    logic [3:0] opt_fast_freq_i, s_axi_wstrb_i, fast_osc_freq_o;
    logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    int miscompares, n_tests;
    wire logic [5:0] en_v = {main_osc_en_o, ext_main_clk_en_o, sub_osc_en_o,
                             ext_sub_clk_en_o, fast_osc_en_o, slow_osc_en_o};
    cgc_top uut (.*);
    cgc_src_model src (.hs_en_i(main_osc_en_o), .hs_run_i(hs_run), .fast_en_i(fast_osc_en_o),
                       .hs_tick_o(hs_clk_tick_i), .fast_tick_o(fast_clk_tick_i));
    // ****************
    // Tasks
    // ****************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task conclude();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task step();
        @(posedge sys_clk_i);
        #1;
    endtask
    // Valids held until their own ready; answer waited for with no fixed latency
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        @(posedge sys_clk_i);
        {s_axi_awaddr_i, s_axi_wdata_i, s_axi_wstrb_i} <= {a, d, s};
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
        do begin
            @(posedge sys_clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (s_axi_bvalid_o !== 1'b1);
        s_axi_bready_i <= 1'b0;
        chk(32'(s_axi_bresp_o), {30'h0, a > 8'h14, 1'b0});
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ex);
        @(posedge sys_clk_i);
        {s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} <= {a, 2'h3};
        do begin
            @(posedge sys_clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (s_axi_rvalid_o !== 1'b1);
        s_axi_rready_i <= 1'b0;
        chk(s_axi_rdata_o, ex);
        chk(32'(s_axi_rresp_o), {30'h0, a > 8'h14, 1'b0});
    endtask
    // Order is stop, halt, wake
    task pulse(input logic [2:0] p);
        @(posedge sys_clk_i);
        {stop_req_i, halt_req_i, wake_i} <= p;
        @(posedge sys_clk_i);
        {stop_req_i, halt_req_i, wake_i} <= 3'h0;
        #1;
    endtask
    // ****************
    // Scenarios
    // ****************
    task t_reset();
        chk(32'(en_v), 32'h03);
        chk(32'(main_src_hs_o), 32'h0);
        rd(8'h00, 32'hC0);
        rd(8'h0C, 32'h6);
        rd(8'h18, 32'h0);
        $display("t_reset done");
    endtask
    task t_osc();
        // Pin mode and RTC source are set by software outside this block
        wr(8'h00, 32'h00);
        step();
        chk(32'(en_v), 32'h3F);
        wr(8'h00, 32'hC1, 4'h0);
        wr(8'h20, 32'hC1);
        step();
        chk(32'(en_v), 32'h3F);
        wr(8'h00, 32'h81);
        step();
        chk(32'(en_v), 32'h0D);
        wr(8'h00, 32'h40);
        step();
        chk(32'(en_v), 32'h33);
        $display("t_osc done");
    endtask
    task t_freq();
        for (int i = 0; i <= 10; i++) begin
            wr(8'h0C, i);
            step();
            chk(32'(fast_osc_freq_o), (i > 9) ? 32'h9 : i);
        end
        wr(8'h0C, 32'h6);
        $display("t_freq done");
    endtask
    task t_switch();
        wr(8'h04, 32'h10);
        repeat (100) if (main_src_hs_o !== 1'b1) step();
        rd(8'h04, 32'h30);
        hs_run = 1'b0;
        wr(8'h04, 32'h00);
        repeat (30) step();
        chk(32'(main_src_hs_o), 32'h1);
        rd(8'h14, 32'h0C);
        hs_run = 1'b1;
        repeat (100) if (main_src_hs_o !== 1'b0) step();
        chk(32'(main_src_hs_o), 32'h0);
        $display("t_switch done");
    endtask
    task t_pll();
        wr(8'h0C, 32'h0);
        wr(8'h08, 32'h1);
        step();
        chk(32'(pll_en_o), 32'h0);
        wr(8'h0C, 32'h6);
        step();
        wr(8'h08, 32'h7);
        step();
        chk(32'({pll_en_o, pll_out_sel_o, pll_div4_o}), 32'h7);
        pulse(3'h4);
        chk(32'({stop_refused_o, stop_mode_o}), 32'h2);
        rd(8'h14, 32'h14);
        wr(8'h14, 32'h10);
        rd(8'h14, 32'h04);
        wr(8'h08, 32'h1);
        wr(8'h08, 32'h0);
        step();
        chk(32'(pll_en_o), 32'h0);
        $display("t_pll done");
    endtask
    task t_standby();
        pulse(3'h2);
        step();
        chk(32'({halt_mode_o, slow_osc_en_o}), 32'h2);
        pulse(3'h1);
        step();
        chk(32'({halt_mode_o, slow_osc_en_o}), 32'h1);
        wr(8'h10, 32'h10);
        pulse(3'h2);
        step();
        chk(32'({halt_mode_o, slow_osc_en_o}), 32'h3);
        pulse(3'h1);
        pulse(3'h4);
        step();
        chk(32'(en_v), 32'h01);
        pulse(3'h1);
        step();
        chk(32'(en_v), 32'h33);
        $display("t_standby done");
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    // Watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        miscompares++;
        conclude();
    end
    initial begin
        {rst_i, ce_i, hs_run, opt_wdt_enable_i, opt_wdt_standby_i} = 5'h1E;
        {stop_req_i, halt_req_i, wake_i, s_axi_awvalid_i, s_axi_wvalid_i} = 5'h00;
        {s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i, opt_fast_freq_i} = 7'h06;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i} = 52'h0;
        {miscompares, n_tests} = 64'h0;
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (2) step();
        t_reset();
        t_osc();
        t_freq();
        t_switch();
        t_pll();
        t_standby();
        conclude();
    end
endmodule
`default_nettype wire
